/* File: tfc_pkg.sv */
// tfc_pkg: offsets, field layout, write masks and carriers of the trace filter control block
// assumes a single core clock; all users import the whole package
package tfc_pkg;
  localparam int ADDR_W = 12;
  localparam int CNT_W = 22;
  localparam int BYTES_W = 4;
  // register byte offsets on the debug port
  localparam logic [11:0] OFF_TS = 12'h030;
  localparam logic [11:0] OFF_SYNC = 12'h034;
  localparam logic [11:0] OFF_ID = 12'h040;
  localparam logic [11:0] OFF_VIEW = 12'h080;
  localparam logic [11:0] OFF_RANGE = 12'h084;
  localparam logic [11:0] OFF_SS = 12'h088;
  localparam logic [11:0] OFF_VIRTUAL_MACHINE_IDENTIFIER_LO = 12'h640;
  localparam logic [11:0] OFF_VIRTUAL_MACHINE_IDENTIFIER_HI = 12'h644;
  localparam logic [11:0] OFF_VIRTUAL_MACHINE_IDENTIFIER_MASK = 12'h688;
  // writable bits; everything else reads as zero except the start/stop status at SS_BIT of the view register
  localparam logic [31:0] TS_WMASK = 32'h0000_008F;
  localparam logic [31:0] SYNC_WMASK = 32'h0000_001F;
  localparam logic [31:0] ID_WMASK = 32'h0000_007F;
  localparam logic [31:0] VIEW_WMASK = 32'h007B_0C8F;
  localparam logic [31:0] RANGE_WMASK = 32'h000F_000F;
  localparam logic [31:0] SS_WMASK = 32'h00FF_00FF;
  localparam logic [31:0] VMASK_WMASK = 32'h0000_000F;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  // field positions
  localparam int TYPE_BIT = 7;
  localparam int NS_LSB = 20;
  localparam int S_LSB = 16;
  localparam int ERR_BIT = 11;
  localparam int RST_BIT = 10;
  localparam int SS_BIT = 9;
  localparam int EXCL_LSB = 16;
  localparam int STOP_LSB = 16;
  localparam logic [4:0] PERIOD_OFF = 5'h00;
  localparam logic [4:0] PERIOD_MAX = 5'h14;
  localparam logic [1:0] LVL_TOP = 2'h3;
  localparam logic [1:0] LVL_HYP = 2'h2;
  localparam logic [CNT_W-1:0] CNT_ONE = 22'h00_0001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 22'h00_0000;

  // one register access from either port
  typedef struct packed {
    logic valid;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
  } tfc_req_t;

  // one retired instruction or exception from the core
  typedef struct packed {
    logic valid;
    logic secure;
    logic [1:0] level;
    logic serror;
    logic reset_exc;
  } tfc_instr_t;

  // resource event chosen by a type bit and a four-bit single or three-bit pair selector
  function automatic logic tfc_pick(input logic [7:0] ctl, input logic [15:0] single,
                                    input logic [7:0] pair);
    if (ctl[TYPE_BIT]) begin
      return pair[ctl[2:0]];
    end
    return single[ctl[3:0]];
  endfunction

  // period in bytes, out-of-range programming clamped to the largest period
  function automatic logic [CNT_W-1:0] tfc_period_bytes(input logic [4:0] n);
    return CNT_ONE << ((n > PERIOD_MAX) ? PERIOD_MAX : n);
  endfunction
endpackage

/* File: tfc_trace_filter.sv */
// tfc_trace_filter: register file, sync period, timestamp and instruction trace filtering
// assumes all inputs come from logic on core_clk; debug and memory-mapped ports are simple
// request/acknowledge ports with one-cycle answers.
`timescale 1ns/1ps
module tfc_trace_filter
  import tfc_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire tfc_req_t dbg_req,
  output logic dbg_ack,
  output logic [31:0] dbg_rdata,
  input wire tfc_req_t mm_req,
  output logic mm_ack,
  output logic [31:0] mm_rdata,
  input wire logic trace_unit_enabled,
  input wire logic [BYTES_W-1:0] trace_bytes,
  input wire logic other_sync,
  input wire logic [15:0] single_res,
  input wire logic [7:0] pair_res,
  input wire logic [3:0] range_hit,
  input wire logic [7:0] addr_hit,
  input wire logic [31:0] cur_virtual_machine_identifier,
  input wire tfc_instr_t instr,
  output logic sync_req,
  output logic [6:0] stream_identifier,
  output logic ts_insert,
  output logic instr_traced,
  output logic start_stop_state,
  output logic virtual_machine_identifier_match
);

  logic [31:0] ts_ctl;
  logic [31:0] sync_period;
  logic [31:0] id_reg;
  logic [31:0] view_ctl;
  logic [31:0] range_sel;
  logic [31:0] ss_sel;
  logic [31:0] virtual_machine_identifier_value;
  logic [31:0] virtual_machine_identifier_mask;
  logic [CNT_W-1:0] byte_cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [CNT_W-1:0] period_bytes;
  logic periodic_hit;
  logic prev_traced;
  logic view_event;
  logic level_ok;
  logic included;
  logic excluded;
  logic view_now;
  logic next_traced;
  logic start_hit;
  logic stop_hit;
  logic dbg_wr;
  logic mm_wr;
  logic sync_wr;
  logic virtual_machine_identifier_wr;
  logic [31:0] virtual_machine_identifier_wdata;
  logic next_match;

  // write strobes; the debug port wins when both ports write the value in one cycle
  assign dbg_wr = dbg_req.valid & dbg_req.write;
  assign mm_wr = mm_req.valid & mm_req.write;
  assign sync_wr = dbg_wr & (dbg_req.addr == OFF_SYNC);
  assign virtual_machine_identifier_wr = ((dbg_wr & (dbg_req.addr == OFF_VIRTUAL_MACHINE_IDENTIFIER_LO)) |
                    (mm_wr & (mm_req.addr == OFF_VIRTUAL_MACHINE_IDENTIFIER_LO))) & ~trace_unit_enabled;
  assign virtual_machine_identifier_wdata = (dbg_wr & (dbg_req.addr == OFF_VIRTUAL_MACHINE_IDENTIFIER_LO)) ? dbg_req.wdata : mm_req.wdata;

  // control registers; unwritable bits are dropped on the way in so they read zero, apart from the view status bit
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ts_ctl <= ZERO_WORD;
      sync_period <= ZERO_WORD;
      id_reg <= ZERO_WORD;
      view_ctl <= ZERO_WORD;
      range_sel <= ZERO_WORD;
      ss_sel <= ZERO_WORD;
      virtual_machine_identifier_mask <= ZERO_WORD;
    end else if (dbg_wr) begin
      unique case (dbg_req.addr)
        OFF_TS: ts_ctl <= dbg_req.wdata & TS_WMASK;
        OFF_SYNC: sync_period <= dbg_req.wdata & SYNC_WMASK;
        OFF_ID: id_reg <= dbg_req.wdata & ID_WMASK;
        OFF_VIEW: view_ctl <= dbg_req.wdata & VIEW_WMASK;
        OFF_RANGE: range_sel <= dbg_req.wdata & RANGE_WMASK;
        OFF_SS: ss_sel <= dbg_req.wdata & SS_WMASK;
        OFF_VIRTUAL_MACHINE_IDENTIFIER_MASK: virtual_machine_identifier_mask <= dbg_req.wdata & VMASK_WMASK;
        default: ;
      endcase
    end
  end

  // identifier value, locked while tracing so a live comparison never sees a torn value
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      virtual_machine_identifier_value <= ZERO_WORD;
    end else if (virtual_machine_identifier_wr) begin
      virtual_machine_identifier_value <= virtual_machine_identifier_wdata;
    end
  end

  // debug port read data and acknowledge, one cycle after the request
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dbg_ack <= 1'b0;
      dbg_rdata <= ZERO_WORD;
    end else begin
      dbg_ack <= dbg_req.valid;
      dbg_rdata <= ZERO_WORD;
      if (dbg_req.valid & ~dbg_req.write) begin
        unique case (dbg_req.addr)
          OFF_TS: dbg_rdata <= ts_ctl;
          OFF_SYNC: dbg_rdata <= sync_period;
          OFF_ID: dbg_rdata <= id_reg;
          OFF_VIEW: dbg_rdata <= view_ctl | (32'(start_stop_state) << SS_BIT);
          OFF_RANGE: dbg_rdata <= range_sel;
          OFF_SS: dbg_rdata <= ss_sel;
          OFF_VIRTUAL_MACHINE_IDENTIFIER_LO: dbg_rdata <= virtual_machine_identifier_value;
          OFF_VIRTUAL_MACHINE_IDENTIFIER_MASK: dbg_rdata <= virtual_machine_identifier_mask;
          default: dbg_rdata <= ZERO_WORD; // reserved upper half and unmapped read zero
        endcase
      end
    end
  end

  // memory-mapped port only maps the identifier value
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mm_ack <= 1'b0;
      mm_rdata <= ZERO_WORD;
    end else begin
      mm_ack <= mm_req.valid;
      mm_rdata <= (mm_req.valid & ~mm_req.write & (mm_req.addr == OFF_VIRTUAL_MACHINE_IDENTIFIER_LO)) ?
                  virtual_machine_identifier_value : ZERO_WORD;
    end
  end

  assign stream_identifier = id_reg[6:0];

  // byte counter: remainder carried so bursts straddling the period are not lost;
  // a period write restarts the count so a shorter period cannot burst out a backlog
  assign period_bytes = tfc_period_bytes(sync_period[4:0]);
  assign next_cnt = byte_cnt + CNT_W'(trace_bytes);
  assign periodic_hit = (sync_period[4:0] != PERIOD_OFF) && (next_cnt >= period_bytes);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      byte_cnt <= CNT_ZERO;
    end else if (sync_period[4:0] == PERIOD_OFF) begin
      byte_cnt <= CNT_ZERO;
    end else if (sync_wr) begin
      byte_cnt <= CNT_ZERO;
    end else if (periodic_hit) begin
      byte_cnt <= next_cnt - period_bytes;
    end else begin
      byte_cnt <= next_cnt;
    end
  end

  // sync and timestamp requests are registered pulses
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sync_req <= 1'b0;
      ts_insert <= 1'b0;
    end else begin
      sync_req <= periodic_hit | other_sync;
      ts_insert <= tfc_pick(ts_ctl[7:0], single_res, pair_res);
    end
  end

  // start/stop logic; stop wins if both fire so a shared comparator cannot restart trace
  assign start_hit = |(ss_sel[7:0] & addr_hit);
  assign stop_hit = |(ss_sel[STOP_LSB+7:STOP_LSB] & addr_hit);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      start_stop_state <= 1'b0;
    end else if (stop_hit) begin
      start_stop_state <= 1'b0;
    end else if (start_hit) begin
      start_stop_state <= 1'b1;
    end
  end

  // view decision: event, level gate, include/exclude ranges and start/stop state
  assign view_event = tfc_pick(view_ctl[7:0], single_res, pair_res);
  always_comb begin
    level_ok = 1'b0;
    if (instr.secure) begin
      // level 2 has no secure gate and never passes the level check
      if (instr.level != LVL_HYP) begin
        level_ok = ~view_ctl[S_LSB + 32'(instr.level)];
      end
    end else if (instr.level != LVL_TOP) begin
      level_ok = ~view_ctl[NS_LSB + 32'(instr.level)];
    end
  end
  assign included = (range_sel[3:0] == 4'h0) | (|(range_sel[3:0] & range_hit));
  assign excluded = |(range_sel[EXCL_LSB+3:EXCL_LSB] & range_hit);
  assign view_now = view_event & level_ok & included & ~excluded & start_stop_state;

  // exceptions follow the previous item unless forced by their control bit
  always_comb begin
    if (instr.serror) begin
      next_traced = view_ctl[ERR_BIT] | prev_traced;
    end else if (instr.reset_exc) begin
      next_traced = view_ctl[RST_BIT] | prev_traced;
    end else begin
      next_traced = view_now;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      prev_traced <= 1'b0;
      instr_traced <= 1'b0;
    end else begin
      instr_traced <= instr.valid & next_traced;
      if (instr.valid) begin
        prev_traced <= next_traced;
      end
    end
  end

  // masked identifier comparison, one byte per mask bit
  always_comb begin
    next_match = 1'b1;
    for (int b = 0; b < 4; b++) begin
      if (!virtual_machine_identifier_mask[b] && (cur_virtual_machine_identifier[8*b +: 8] != virtual_machine_identifier_value[8*b +: 8])) begin
        next_match = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      virtual_machine_identifier_match <= 1'b0;
    end else begin
      virtual_machine_identifier_match <= next_match;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // sync requests: periodic ones only with a live period, other causes always pass
  a_sync_off: assert property (
      (sync_period[4:0] == PERIOD_OFF) && !other_sync |=> !sync_req)
    else $error("periodic sync while period is zero");
  a_sync_other: assert property (other_sync |=> sync_req)
    else $error("other sync cause dropped");
  a_sync_bound: assert property (
      (sync_period[4:0] != PERIOD_OFF) |-> byte_cnt < period_bytes)
    else $error("sync byte counter ran past its period");
  a_ts_event: assert property (
      (ts_ctl[TYPE_BIT] ? pair_res[ts_ctl[2:0]] : single_res[ts_ctl[3:0]]) |=> ts_insert)
    else $error("timestamp event not inserted");
  // level gates, checked on plain instructions so exception forcing cannot mask them
  a_ns_top: assert property (
      instr.valid && !instr.secure && instr.level == LVL_TOP
      && !instr.serror && !instr.reset_exc |=> !instr_traced)
    else $error("non-secure top level traced");
  a_s_hyp: assert property (
      instr.valid && instr.secure && instr.level == LVL_HYP
      && !instr.serror && !instr.reset_exc |=> !instr_traced)
    else $error("secure level two traced");
  a_gate_set: assert property (
      instr.valid && !instr.secure && view_ctl[NS_LSB] && instr.level == 2'h0
      && !instr.serror && !instr.reset_exc |=> !instr_traced)
    else $error("gated level still traced");
  a_err_force: assert property (
      instr.valid && instr.serror && view_ctl[ERR_BIT] |=> instr_traced)
    else $error("forced error exception not traced");
  a_rst_force: assert property (
      instr.valid && !instr.serror && instr.reset_exc && view_ctl[RST_BIT] |=> instr_traced)
    else $error("forced reset exception not traced");
  a_excl_range: assert property (
      instr.valid && excluded && !instr.serror && !instr.reset_exc |=> !instr_traced)
    else $error("excluded range traced");
  a_ss_start: assert property (start_hit && !stop_hit |=> start_stop_state)
    else $error("start match did not start trace");
  a_ss_stop: assert property (stop_hit |=> !start_stop_state)
    else $error("stop match did not stop trace");
  a_virtual_machine_identifier_lock: assert property (trace_unit_enabled |=> $stable(virtual_machine_identifier_value))
    else $error("identifier value changed while tracing");
  a_mask_all: assert property (virtual_machine_identifier_mask[3:0] == 4'hF |=> virtual_machine_identifier_match)
    else $error("fully masked compare did not match");
endmodule

/* File: tfc_reg_master.sv */
// tfc_reg_master: behavioural register master standing in for a debugger or software
// assumes it shares core_clk with the filter block; accesses start on a falling edge
`timescale 1ns/1ps
module tfc_reg_master
  import tfc_pkg::*;
(
  input wire logic core_clk,
  output tfc_req_t req,
  input wire logic ack,
  input wire logic [31:0] rdata
);
  initial begin
    req = '0;
  end
  // valid lasts one cycle; the released payload is inverted so stale fields never match
  task automatic access(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic ok);
    int n;
    n = 0;
    @(negedge core_clk);
    req = {1'b1, wr, a, d};
    @(negedge core_clk);
    req = {1'b0, ~wr, ~a, ~d};
    // bounded wait, so a silent port cannot hang the run
    while (ack !== 1'b1 && n < 4) begin
      @(negedge core_clk);
      n++;
    end
    rd = rdata;
    ok = (ack === 1'b1);
  endtask
endmodule

/* File: test_trace_filter_control.sv */
// test_trace_filter_control: self-checking bench for the trace filter control block
// assumes tfc_pkg and tfc_reg_master are compiled first; one 25 MHz clock
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin bad_count++; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module test_trace_filter_control
  import tfc_pkg::*;
;
  logic core_clk, nrst, trace_unit_enabled, other_sync, ok;
  tfc_req_t dbg_req, mm_req;
  tfc_instr_t instr;
  logic dbg_ack, mm_ack, sync_req, ts_insert, instr_traced, start_stop_state, virtual_machine_identifier_match;
  logic [31:0] dbg_rdata, mm_rdata, cur_virtual_machine_identifier, rd;
  logic [3:0] trace_bytes, range_hit;
  logic [15:0] single_res;
  logic [7:0] pair_res, addr_hit;
  logic [6:0] stream_identifier;
  int bad_count, checked, cycles, n;
  // register rows: offset beside the value that reads back after writing all ones;
  // the period row keeps its field at the legal maximum of 20
  localparam int ROWS = 10;
  localparam logic [11:0] ROW_ADDR [ROWS] = '{OFF_TS, OFF_SYNC, OFF_ID, OFF_VIEW, OFF_RANGE,
    OFF_SS, OFF_VIRTUAL_MACHINE_IDENTIFIER_LO, OFF_VIRTUAL_MACHINE_IDENTIFIER_HI, OFF_VIRTUAL_MACHINE_IDENTIFIER_MASK, 12'h0FC};
  localparam logic [31:0] ROW_EXP [ROWS] = '{TS_WMASK, 32'h0000_0014, ID_WMASK, VIEW_WMASK,
    RANGE_WMASK, SS_WMASK, 32'hFFFF_FFFF, ZERO_WORD, VMASK_WMASK, ZERO_WORD};

  tfc_trace_filter dut (.core_clk(core_clk), .nrst(nrst), .dbg_req(dbg_req),
    .dbg_ack(dbg_ack), .dbg_rdata(dbg_rdata), .mm_req(mm_req), .mm_ack(mm_ack),
    .mm_rdata(mm_rdata), .trace_unit_enabled(trace_unit_enabled),
    .trace_bytes(trace_bytes), .other_sync(other_sync), .single_res(single_res),
    .pair_res(pair_res), .range_hit(range_hit), .addr_hit(addr_hit), .cur_virtual_machine_identifier(cur_virtual_machine_identifier),
    .instr(instr), .sync_req(sync_req), .stream_identifier(stream_identifier),
    .ts_insert(ts_insert), .instr_traced(instr_traced),
    .start_stop_state(start_stop_state), .virtual_machine_identifier_match(virtual_machine_identifier_match));
  tfc_reg_master m_dbg (.core_clk(core_clk), .req(dbg_req), .ack(dbg_ack), .rdata(dbg_rdata));
  tfc_reg_master m_mm (.core_clk(core_clk), .req(mm_req), .ack(mm_ack), .rdata(mm_rdata));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // one register access on the debug port (mm = 0) or the memory-mapped port
  task automatic rw(input bit mm, input logic wr, input logic [11:0] a, input logic [31:0] d);
    if (mm) begin
      m_mm.access(wr, a, d, rd, ok);
    end else begin
      m_dbg.access(wr, a, d, rd, ok);
    end
    `CHK("ack", 1'b1, ok)
  endtask
  // one retired item; the traced flag follows one cycle later
  task automatic put_instr(input logic sec, input logic [1:0] lvl, input logic [1:0] exc,
                           input logic [3:0] rh, input logic ex, input string nm);
    @(negedge core_clk);
    instr = {1'b1, sec, lvl, exc};
    range_hit = rh;
    @(negedge core_clk);
    instr = '0;
    range_hit = 4'h0;
    `CHK(nm, ex, instr_traced)
  endtask

  initial begin
    nrst = 1'b0;
    {trace_unit_enabled, other_sync, trace_bytes, single_res, pair_res, range_hit, addr_hit,
      cur_virtual_machine_identifier, instr} = '0;
    repeat (12) @(negedge core_clk);
    nrst = 1'b1;
    for (int i = 0; i < ROWS; i++) begin
      rw(0, 0, ROW_ADDR[i], ZERO_WORD);
      `CHK("reset value", ZERO_WORD, rd)
      rw(0, 1, ROW_ADDR[i], (ROW_ADDR[i] == OFF_SYNC) ? 32'hFFFF_FFF4 : 32'hFFFF_FFFF);
      rw(0, 0, ROW_ADDR[i], ZERO_WORD);
      `CHK("readback", ROW_EXP[i], rd)
    end
    `CHK("stream_identifier", 7'h7F, stream_identifier)
    $display("test registers done");
    // period 8 with 8 bytes a cycle: one request every 32 cycles, ten in all
    rw(0, 1, OFF_SYNC, 32'h0000_0008);
    trace_bytes = 4'h8;
    n = 0;
    for (int i = 0; i < 322; i++) begin
      @(negedge core_clk);
      if (i == 319) trace_bytes = 4'h0;
      n += int'(sync_req === 1'b1);
    end
    `CHK("sync count", 10, n)
    rw(0, 1, OFF_SYNC, ZERO_WORD);
    trace_bytes = 4'hF;
    n = 0;
    for (int i = 0; i < 64; i++) begin
      @(negedge core_clk);
      other_sync = (i == 30);
      n += int'(sync_req === 1'b1);
    end
    trace_bytes = 4'h0;
    `CHK("sync other only", 1, n)
    $display("test sync done");
    rw(0, 1, OFF_TS, 32'h0000_0005);
    single_res = 16'h0020;
    @(negedge core_clk);
    single_res = 16'h0010;
    `CHK("ts selected", 1'b1, ts_insert)
    @(negedge core_clk);
    `CHK("ts other", 1'b0, ts_insert)
    rw(0, 1, OFF_TS, 32'h0000_0083);
    single_res = 16'h0000;
    pair_res = 8'h08;
    @(negedge core_clk);
    `CHK("ts pair", 1'b1, ts_insert)
    $display("test timestamp done");
    // level 1 non-secure gated off, range 0 excluded, comparator 1 starts, 0 stops
    rw(0, 1, OFF_VIEW, 32'h0020_0000);
    rw(0, 1, OFF_RANGE, 32'h0001_0000);
    rw(0, 1, OFF_SS, 32'h0001_0002);
    single_res = 16'h0001;
    addr_hit = 8'h02;
    @(negedge core_clk);
    addr_hit = 8'h00;
    `CHK("started", 1'b1, start_stop_state)
    rw(0, 0, OFF_VIEW, ZERO_WORD);
    `CHK("status bit", 32'h0020_0200, rd)
    put_instr(0, 0, 0, 0, 1, "ns level 0");
    put_instr(0, 1, 0, 0, 0, "ns level 1");
    put_instr(0, 0, 0, 1, 0, "excluded");
    put_instr(0, 0, 0, 2, 1, "other range");
    put_instr(1, 2, 0, 0, 0, "s level 2");
    put_instr(1, 3, 0, 0, 1, "s level 3");
    put_instr(0, 1, 0, 0, 0, "ns level 1");
    put_instr(0, 0, 2, 0, 0, "error after gap");
    put_instr(0, 0, 1, 0, 0, "reset after gap");
    rw(0, 1, OFF_VIEW, 32'h0020_0C00);
    put_instr(0, 1, 2, 0, 1, "forced error");
    put_instr(0, 1, 0, 0, 0, "ns level 1");
    put_instr(0, 1, 1, 0, 1, "forced reset");
    single_res = 16'h0000;
    put_instr(0, 0, 0, 0, 0, "view off");
    rw(0, 1, OFF_VIEW, 32'h0000_0083);
    put_instr(0, 0, 0, 0, 1, "pair view");
    put_instr(0, 3, 0, 0, 0, "ns level 3");
    rw(0, 1, OFF_VIEW, 32'h0010_0083);
    put_instr(0, 0, 0, 0, 0, "ns level 0 gated");
    addr_hit = 8'h03;
    @(negedge core_clk);
    addr_hit = 8'h00;
    `CHK("stop wins", 1'b0, start_stop_state)
    rw(0, 0, OFF_VIEW, ZERO_WORD);
    `CHK("status stopped", 32'h0010_0083, rd)
    $display("test filter done");
    rw(0, 1, OFF_VIRTUAL_MACHINE_IDENTIFIER_MASK, ZERO_WORD);
    rw(0, 1, OFF_VIRTUAL_MACHINE_IDENTIFIER_LO, 32'h1234_5678);
    rw(1, 0, OFF_VIRTUAL_MACHINE_IDENTIFIER_LO, ZERO_WORD);
    `CHK("mm read", 32'h1234_5678, rd)
    trace_unit_enabled = 1'b1;
    rw(0, 1, OFF_VIRTUAL_MACHINE_IDENTIFIER_LO, 32'hFFFF_FFFF);
    rw(1, 1, OFF_VIRTUAL_MACHINE_IDENTIFIER_LO, 32'hFFFF_FFFF);
    rw(0, 0, OFF_VIRTUAL_MACHINE_IDENTIFIER_LO, ZERO_WORD);
    `CHK("locked value", 32'h1234_5678, rd)
    trace_unit_enabled = 1'b0;
    rw(1, 1, OFF_VIRTUAL_MACHINE_IDENTIFIER_LO, 32'hAB34_5678);
    cur_virtual_machine_identifier = 32'h0034_5678;
    rw(0, 0, OFF_VIRTUAL_MACHINE_IDENTIFIER_LO, ZERO_WORD);
    `CHK("mm write", 32'hAB34_5678, rd)
    `CHK("byte compared", 1'b0, virtual_machine_identifier_match)
    rw(0, 1, OFF_VIRTUAL_MACHINE_IDENTIFIER_MASK, 32'h0000_0008);
    @(negedge core_clk);
    `CHK("byte ignored", 1'b1, virtual_machine_identifier_match)
    $display("test identifier done");
    // mid-run reset: start trace first so the clear of start_stop_state is visible
    addr_hit = 8'h02;
    @(negedge core_clk);
    addr_hit = 8'h00;
    `CHK("restarted", 1'b1, start_stop_state)
    nrst = 1'b0;
    @(negedge core_clk);
    `CHK("reset state", 1'b0, start_stop_state)
    `CHK("reset identifier", 7'h00, stream_identifier)
    `CHK("reset match", 1'b0, virtual_machine_identifier_match)
    repeat (2) @(negedge core_clk);
    nrst = 1'b1;
    rw(0, 0, OFF_VIRTUAL_MACHINE_IDENTIFIER_LO, ZERO_WORD);
    `CHK("reset value word", ZERO_WORD, rd)
    $display("test reset done");
    wrap_up();
  end
endmodule
